/* File: hdl/battery_power_manager_defines.vh */
// constants for the battery power manager
`ifndef BATTERY_POWER_MANAGER_DEFINES_VH
`define BATTERY_POWER_MANAGER_DEFINES_VH

// clock and base tick
`define CLK_KHZ          50000
`define TICK_MS          100
`define TICK_CYC         (`TICK_MS * `CLK_KHZ)

// periods in seconds (low-battery repeat in minutes), converted to base ticks
`define STAB_S           30
`define STAB_TICKS       (`STAB_S * 1000 / `TICK_MS)
`define STEP_S           10
`define STEP_TICKS       (`STEP_S * 1000 / `TICK_MS)
`define LOWBAT_MIN       5
`define LOWBAT_TICKS     (`LOWBAT_MIN * 60 * 1000 / `TICK_MS)

// gain figures: step size in 1 dB units, limits in steps
`define INST_STEP_DB     3
`define INST_MAX_STEPS   2
`define AVG_MAX_STEPS    18

// power-management schemes
`define SCHEME_SHALLOW   2'h0
`define SCHEME_DEEP      2'h1
`define SCHEME_ADVANCED  2'h2

// register byte offsets
`define REG_CTRL         12'h000
`define REG_PORDLY       12'h004
`define REG_LBTHR        12'h008
`define REG_STATUS       12'h00C

// control register fields
`define CTRL_SCHEME_LSB  0
`define CTRL_SCHEME_MSB  1
`define CTRL_LBEN_BIT    2

// reset values
`define CTRL_RST         3'h0
`define PORDLY_RST       8'h14
`define LBTHR_RST        4'h8

`endif

/* File: hdl/battery_power_manager.v */
// supply supervision, gain reduction and power-on control
`timescale 1ns/10ps
`include "battery_power_manager_defines.vh"

module battery_power_manager #(
  parameter TICK_CYCLES = `TICK_CYC
) (
  input  wire        clk_i,
  input  wire        rstn_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire        inst_above_095_i,
  input  wire        inst_above_100_i,
  input  wire        inst_above_110_i,
  input  wire        avg_above_095_i,
  input  wire        avg_above_110_i,
  input  wire        above_060_i,
  input  wire        logic_ok_i,
  input  wire        lowbat_below_i,
  input  wire        button_i,
  output reg         audio_en_o,
  output reg         mute_o,
  output reg  [5:0]  atten_db_o,
  output reg         mem_restore_prev_o,
  output reg         mem_load_a_o,
  output reg         lowbat_ind_o,
  output reg         button_press_o,
  output wire [3:0]  lowbat_thresh_o
);

  localparam [1:0] ST_PORDLY = 2'h0;
  localparam [1:0] ST_RUN    = 2'h1;
  localparam [1:0] ST_OFF    = 2'h2;

  // full-width values, cut to the counter widths below
  localparam integer TICK_LAST_W = TICK_CYCLES - 1;
  localparam integer STAB_LAST_W = `STAB_TICKS - 1;
  localparam integer STEP_LAST_W = `STEP_TICKS - 1;
  localparam integer LB_LAST_W   = `LOWBAT_TICKS - 1;
  localparam integer INST_MAX_W  = `INST_MAX_STEPS;
  localparam integer AVG_MAX_W   = `AVG_MAX_STEPS;
  localparam integer INST_DB_W   = `INST_STEP_DB;

  localparam [22:0] TICK_LAST  = TICK_LAST_W[22:0];
  localparam [8:0]  STAB_LAST  = STAB_LAST_W[8:0];
  localparam [6:0]  STEP_LAST  = STEP_LAST_W[6:0];
  localparam [11:0] LB_LAST    = LB_LAST_W[11:0];
  localparam [1:0]  INST_MAX   = INST_MAX_W[1:0];
  localparam [4:0]  AVG_MAX    = AVG_MAX_W[4:0];
  localparam [5:0]  INST_DB    = INST_DB_W[5:0];

  // comparator and pin synchronisers
  reg  [8:0]  sync1_r;
  reg  [8:0]  sync2_r;
  wire        i095;
  wire        i100;
  wire        i110;
  wire        a095;
  wire        a110;
  wire        ok060;
  wire        logic_ok;
  wire        lb_below;
  wire        button;

  // registers reached over the bus
  reg  [2:0]  ctrl_r;
  reg  [7:0]  pordly_r;
  reg  [3:0]  lbthr_r;
  wire [1:0]  scheme;
  wire        lb_en;
  wire        adv;
  wire        deep;

  // timing and state
  reg  [22:0] tick_cnt_r;
  reg         tick_r;
  reg  [1:0]  state_r;
  reg  [7:0]  por_cnt_r;
  reg         fell06_r;
  reg         lv_mute_r;
  reg  [1:0]  inst_red_r;
  reg         stab_r;
  reg  [8:0]  mon_cnt_r;
  reg         bad110_r;
  reg         bad100_r;
  reg  [4:0]  avg_red_r;
  reg         avg_mute_r;
  reg  [6:0]  step_cnt_r;
  reg         lb_active_r;
  reg  [11:0] lb_cnt_r;
  reg         button_d_r;
  wire        run;
  wire        go_off;
  wire        wake;
  wire        mon_end;
  wire        wr_en;
  wire        rd_en;
  wire        addr_hit;

  // only the second stage is read anywhere
  // supply flags reset high: a zero delay must not see a false brownout
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_r <= 9'h07F;
      sync2_r <= 9'h07F;
    end else begin
      sync1_r <= {button_i, lowbat_below_i, logic_ok_i, above_060_i,
                  avg_above_110_i, avg_above_095_i, inst_above_110_i,
                  inst_above_100_i, inst_above_095_i};
      sync2_r <= sync1_r;
    end
  end

  assign i095     = sync2_r[0];
  assign i100     = sync2_r[1];
  assign i110     = sync2_r[2];
  assign a095     = sync2_r[3];
  assign a110     = sync2_r[4];
  assign ok060    = sync2_r[5];
  assign logic_ok = sync2_r[6];
  assign lb_below = sync2_r[7];
  assign button   = sync2_r[8];

  // apb slave, zero wait states
  assign pready_o  = 1'b1;
  assign addr_hit  = (paddr_i == `REG_CTRL) || (paddr_i == `REG_PORDLY) ||
                     (paddr_i == `REG_LBTHR) || (paddr_i == `REG_STATUS);
  assign pslverr_o = psel_i & penable_i & ~addr_hit;
  assign wr_en     = psel_i & penable_i & pwrite_i;
  assign rd_en     = psel_i & ~penable_i & ~pwrite_i;

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r   <= `CTRL_RST;
      pordly_r <= `PORDLY_RST;
      lbthr_r  <= `LBTHR_RST;
    end else if (wr_en) begin
      case (paddr_i)
        `REG_CTRL:   ctrl_r   <= pwdata_i[2:0];
        `REG_PORDLY: pordly_r <= pwdata_i[7:0];
        `REG_LBTHR:  lbthr_r  <= pwdata_i[3:0];
        default:     ctrl_r   <= ctrl_r;
      endcase
    end
  end

  // read data captured in setup, stable through the access phase
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_o <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr_i)
        `REG_CTRL:   prdata_o <= {29'h00000000, ctrl_r};
        `REG_PORDLY: prdata_o <= {24'h000000, pordly_r};
        `REG_LBTHR:  prdata_o <= {28'h0000000, lbthr_r};
        `REG_STATUS: prdata_o <= {16'h0000, lb_active_r, fell06_r,
                                  mute_o, avg_red_r, inst_red_r,
                                  state_r, 4'h0};
        default:     prdata_o <= 32'h00000000;
      endcase
    end
  end

  assign scheme          = ctrl_r[`CTRL_SCHEME_MSB:`CTRL_SCHEME_LSB];
  assign lb_en           = ctrl_r[`CTRL_LBEN_BIT];
  assign adv             = (scheme == `SCHEME_ADVANCED);
  assign deep            = (scheme == `SCHEME_DEEP);
  assign lowbat_thresh_o = lbthr_r;

  // base tick divider
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt_r <= 23'h000000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= 23'h000000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 23'h000001;
      tick_r     <= 1'b0;
    end
  end

  // deep waits for the 0.6 V reset, the others drop at the logic level
  assign go_off = deep ? ~ok060 : (~logic_ok | ~ok060);
  assign wake   = adv ? (ok060 & logic_ok) : i110;
  assign run    = (state_r == ST_RUN);

  // power state machine
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r            <= ST_PORDLY;
      por_cnt_r          <= 8'h00;
      fell06_r           <= 1'b0;
      mem_restore_prev_o <= 1'b0;
      mem_load_a_o       <= 1'b0;
    end else begin
      mem_restore_prev_o <= 1'b0;
      mem_load_a_o       <= 1'b0;
      case (state_r)
        ST_PORDLY: begin
          if (por_cnt_r >= pordly_r) begin
            state_r <= ST_RUN;
          end else if (tick_r) begin
            por_cnt_r <= por_cnt_r + 8'h01;
          end
        end
        ST_RUN: begin
          if (go_off) begin
            state_r  <= ST_OFF;
            fell06_r <= ~ok060;
          end
        end
        ST_OFF: begin
          if (!ok060) begin
            fell06_r <= 1'b1;
          end else if (wake) begin
            state_r <= ST_RUN;
            if (fell06_r || deep) begin
              mem_load_a_o <= 1'b1;
            end else begin
              mem_restore_prev_o <= 1'b1;
            end
          end
        end
        default: state_r <= ST_PORDLY;
      endcase
    end
  end

  // level-based mute for shallow and deep schemes
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lv_mute_r <= 1'b0;
    end else if (!run) begin
      lv_mute_r <= 1'b0;
    end else if (!i095) begin
      lv_mute_r <= 1'b1;
    end else if (i110 && !deep) begin
      lv_mute_r <= 1'b0;
    end
  end

  // instantaneous cuts; one counter serves stabilisation and monitoring
  assign mon_end = tick_r && (mon_cnt_r == STAB_LAST);

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      inst_red_r <= 2'h0;
      stab_r     <= 1'b0;
      mon_cnt_r  <= 9'h000;
      bad110_r   <= 1'b0;
      bad100_r   <= 1'b0;
    end else if (!run || !adv) begin
      inst_red_r <= 2'h0;
      stab_r     <= 1'b0;
      mon_cnt_r  <= 9'h000;
      bad110_r   <= 1'b0;
      bad100_r   <= 1'b0;
    end else if (inst_red_r == 2'h0) begin
      if (a095 && !i095) begin
        inst_red_r <= 2'h1;
        stab_r     <= 1'b1;
        mon_cnt_r  <= 9'h000;
      end
    end else if (stab_r) begin
      // dips are not looked at while the supply settles
      if (mon_end) begin
        stab_r    <= 1'b0;
        mon_cnt_r <= 9'h000;
        bad110_r  <= 1'b0;
        bad100_r  <= 1'b0;
      end else if (tick_r) begin
        mon_cnt_r <= mon_cnt_r + 9'h001;
      end
    end else if (!i095 && inst_red_r < INST_MAX) begin
      inst_red_r <= inst_red_r + 2'h1;
      stab_r     <= 1'b1;
      mon_cnt_r  <= 9'h000;
    end else if (mon_end) begin
      if (!bad110_r && i110) begin
        inst_red_r <= 2'h0;
      end else if (inst_red_r == INST_MAX && !bad100_r && i100) begin
        inst_red_r <= 2'h1;
      end
      mon_cnt_r <= 9'h000;
      bad110_r  <= 1'b0;
      bad100_r  <= 1'b0;
    end else begin
      if (tick_r) begin
        mon_cnt_r <= mon_cnt_r + 9'h001;
      end
      if (!i110) begin
        bad110_r <= 1'b1;
      end
      if (!i100) begin
        bad100_r <= 1'b1;
      end
    end
  end

  // average cuts, one step per 10 s, independent of the above
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avg_red_r  <= 5'h00;
      avg_mute_r <= 1'b0;
      step_cnt_r <= 7'h00;
    end else if (!run || !adv) begin
      avg_red_r  <= 5'h00;
      avg_mute_r <= 1'b0;
      step_cnt_r <= 7'h00;
    end else if (!a095) begin
      if (tick_r && step_cnt_r == STEP_LAST) begin
        step_cnt_r <= 7'h00;
        if (avg_red_r < AVG_MAX) begin
          avg_red_r <= avg_red_r + 5'h01;
        end
        if (avg_red_r >= AVG_MAX - 5'h01) begin
          avg_mute_r <= 1'b1;
        end
      end else if (tick_r) begin
        step_cnt_r <= step_cnt_r + 7'h01;
      end
    end else if (a110) begin
      if (avg_mute_r) begin
        avg_mute_r <= 1'b0;
        step_cnt_r <= 7'h00;
      end else if (avg_red_r == 5'h00) begin
        step_cnt_r <= 7'h00;
      end else if (tick_r && step_cnt_r == STEP_LAST) begin
        step_cnt_r <= 7'h00;
        avg_red_r  <= avg_red_r - 5'h01;
      end else if (tick_r) begin
        step_cnt_r <= step_cnt_r + 7'h01;
      end
    end else begin
      step_cnt_r <= 7'h00;
    end
  end

  // low-battery notification; latched until shutdown, repeat pulses gated by the enable bit
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lb_active_r  <= 1'b0;
      lb_cnt_r     <= 12'h000;
      lowbat_ind_o <= 1'b0;
    end else begin
      lowbat_ind_o <= 1'b0;
      if (!run) begin
        lb_active_r <= 1'b0;
        lb_cnt_r    <= 12'h000;
      end else if (!lb_active_r) begin
        if (lb_en && lb_below) begin
          lb_active_r  <= 1'b1;
          lb_cnt_r     <= 12'h000;
          lowbat_ind_o <= 1'b1;
        end
      end else if (tick_r) begin
        if (lb_cnt_r == LB_LAST) begin
          lb_cnt_r     <= 12'h000;
          lowbat_ind_o <= lb_en;
        end else begin
          lb_cnt_r <= lb_cnt_r + 12'h001;
        end
      end
    end
  end

  // button edge; presses during the delay are dropped, not queued
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      button_d_r     <= 1'b0;
      button_press_o <= 1'b0;
    end else begin
      button_d_r     <= button;
      button_press_o <= button & ~button_d_r & run;
    end
  end

  // audio path outputs
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      audio_en_o <= 1'b0;
      mute_o     <= 1'b1;
      atten_db_o <= 6'h00;
    end else begin
      audio_en_o <= run;
      mute_o     <= ~run | (adv ? avg_mute_r : lv_mute_r);
      atten_db_o <= ({4'h0, inst_red_r} * INST_DB) +
                    {1'b0, avg_red_r};
    end
  end

endmodule // battery_power_manager

/* File: bench/supply_model.sv */
// supply comparator flags derived from millivolt levels
`timescale 1ns/10ps
module supply_model #(
  parameter LOGIC_MV = 12'h352
) (
  input  wire [11:0] inst_mv_i,
  input  wire [11:0] avg_mv_i,
  output wire        inst_above_095_o,
  output wire        inst_above_100_o,
  output wire        inst_above_110_o,
  output wire        avg_above_095_o,
  output wire        avg_above_110_o,
  output wire        above_060_o,
  output wire        logic_ok_o
);
  // plain levels, asynchronous to the clock; the design synchronises
  assign inst_above_095_o = inst_mv_i > 12'h3B6;
  assign inst_above_100_o = inst_mv_i > 12'h3E8;
  assign inst_above_110_o = inst_mv_i > 12'h44C;
  assign avg_above_095_o  = avg_mv_i > 12'h3B6;
  assign avg_above_110_o  = avg_mv_i > 12'h44C;
  assign above_060_o      = inst_mv_i > 12'h258;
  assign logic_ok_o       = inst_mv_i > LOGIC_MV;
endmodule // supply_model

/* File: bench/battery_power_manager_assertions.sv */
// concurrent checks on the battery power manager ports
`timescale 1ns/10ps
module battery_power_manager_chk #(
  parameter TICK_CYCLES = 4
) (
  input wire        clk_i,
  input wire        rstn_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire [11:0] paddr_i,
  input wire        pslverr_o,
  input wire        above_060_i,
  input wire        button_i,
  input wire        audio_en_o,
  input wire        mute_o,
  input wire [5:0]  atten_db_o,
  input wire        mem_restore_prev_o,
  input wire        mem_load_a_o,
  input wire        lowbat_ind_o,
  input wire        button_press_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  AST_MUTE_OFF: assert property (!audio_en_o |-> mute_o)
    else $error("audio unmuted while output disabled");
  AST_ATTEN_MAX: assert property (atten_db_o <= 6'h18)
    else $error("attenuation above both limits");
  AST_ATTEN_STEP: assert property ((atten_db_o > $past(atten_db_o)) |->
    ((atten_db_o - $past(atten_db_o)) inside {6'h1, 6'h3, 6'h4}))
    else $error("attenuation rose by an odd amount");
  AST_BTN: assert property (button_press_o |->
    $past(button_i, 3) && !$past(button_i, 4))
    else $error("button pulse without a press");
  AST_RESTORE_ONE: assert property (mem_restore_prev_o |=>
    !mem_restore_prev_o)
    else $error("restore pulse too long");
  AST_LOAD_ONE: assert property (mem_load_a_o |->
    !mem_restore_prev_o ##1 !mem_load_a_o)
    else $error("memory A load pulse bad");
  AST_LOWBAT_GAP: assert property (lowbat_ind_o |=>
    !lowbat_ind_o [*8])
    else $error("indicator repeated too soon");
  AST_OFF: assert property (!above_060_i [*6] |-> !audio_en_o)
    else $error("output on below reset level");
  AST_ATTEN_IDLE: assert property (!audio_en_o [*4] |->
    atten_db_o == 6'h0)
    else $error("attenuation kept while not running");
  AST_SLVERR: assert property (psel_i && penable_i &&
    paddr_i > 12'h00C |-> pslverr_o)
    else $error("unmapped access not refused");
endmodule // battery_power_manager_chk

bind battery_power_manager battery_power_manager_chk #(
  .TICK_CYCLES(TICK_CYCLES)
) u_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .pslverr_o(pslverr_o),
  .above_060_i(above_060_i), .button_i(button_i),
  .audio_en_o(audio_en_o), .mute_o(mute_o), .atten_db_o(atten_db_o),
  .mem_restore_prev_o(mem_restore_prev_o), .mem_load_a_o(mem_load_a_o),
  .lowbat_ind_o(lowbat_ind_o), .button_press_o(button_press_o)
);

/* File: bench/battery_power_manager_tb.sv */
// self-checking bench for the battery power manager
`timescale 1ns/10ps
`include "battery_power_manager_defines.vh"
module battery_power_manager_tb;
  localparam TK = 4;
  reg         clk_i = 0, rstn_i = 0;
  reg         psel_i = 0, penable_i = 0, pwrite_i = 0;
  reg  [11:0] paddr_i = 12'h0, inst_mv = 12'h4B0, avg_mv = 12'h4B0;
  reg  [31:0] pwdata_i = 32'h0, q;
  reg         lowbat_below_i = 0, button_i = 0, err;
  wire [31:0] prdata_o;
  wire        pready_o, pslverr_o, i95, i100, i110, a95, a110, f60, lok;
  wire        audio_en_o, mute_o, rp, la, lb, bp;
  wire [5:0]  atten_db_o;
  wire [3:0]  thr;
  integer     failures = 0, samples_checked = 0;
  integer     n_rp = 0, n_la = 0, n_lb = 0, n_bp = 0;

  always #10 clk_i = ~clk_i;
  // pulse counters; pulses last one cycle so each edge counts once
  always @(posedge clk_i) begin
    n_rp <= n_rp + rp;
    n_la <= n_la + la;
    n_lb <= n_lb + lb;
    n_bp <= n_bp + bp;
  end

  supply_model sup_m (.inst_mv_i(inst_mv), .avg_mv_i(avg_mv),
    .inst_above_095_o(i95), .inst_above_100_o(i100),
    .inst_above_110_o(i110), .avg_above_095_o(a95),
    .avg_above_110_o(a110), .above_060_o(f60), .logic_ok_o(lok));
  battery_power_manager #(.TICK_CYCLES(TK)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .inst_above_095_i(i95),
    .inst_above_100_i(i100), .inst_above_110_i(i110),
    .avg_above_095_i(a95), .avg_above_110_i(a110),
    .above_060_i(f60), .logic_ok_i(lok),
    .lowbat_below_i(lowbat_below_i), .button_i(button_i),
    .audio_en_o(audio_en_o), .mute_o(mute_o), .atten_db_o(atten_db_o),
    .mem_restore_prev_o(rp), .mem_load_a_o(la), .lowbat_ind_o(lb),
    .button_press_o(bp), .lowbat_thresh_o(thr));

  task conclude;
    begin
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [63:0] got, input [63:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("Error %0t: got %0h expected %0h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task tick(input integer n);
    cyc(n * TK);
  endtask
  // bounded wait on enable (sel 0) or attenuation (sel 1)
  task wait_for(input integer sel, input [5:0] v, input integer lim);
    integer k;
    begin
      k = 0;
      while ((sel ? atten_db_o : {5'h0, audio_en_o}) !== v && k < lim) begin
        k = k + 1;
        @(posedge clk_i);
      end
      if (k >= lim) begin
        failures = failures + 1;
        $display("Error %0t: wait ran out", $time);
        conclude;
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      k = 0;
      @(posedge clk_i);
      while (pready_o !== 1'b1 && k < 20) begin
        k = k + 1;
        @(posedge clk_i);
      end
      if (k >= 20) begin
        failures = failures + 1;
        $display("Error %0t: no ready", $time);
        conclude;
      end
      q = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  // new supply levels, then time for sync and response
  task sup(input [11:0] i, input [11:0] a);
    begin
      inst_mv <= i;
      avg_mv <= a;
      cyc(8);
    end
  endtask
  task press;
    begin
      button_i <= 1'b1;
      cyc(4);
      button_i <= 1'b0;
      cyc(6);
    end
  endtask

  initial begin
    cyc(12);
    rstn_i <= 1'b1;
    press;
    apb(0, `REG_CTRL, 0);
    chk(q, {29'h0, `CTRL_RST});
    apb(0, `REG_PORDLY, 0);
    chk(q, {24'h0, `PORDLY_RST});
    apb(0, `REG_LBTHR, 0);
    chk(q, {28'h0, `LBTHR_RST});
    apb(0, 12'h010, 0);
    chk({q, err}, 33'h1);
    cyc(40);
    chk(audio_en_o, 1'b0);
    wait_for(0, 6'h1, 30 * TK);
    chk(n_bp, 0);
    press;
    chk(n_bp, 1);
    sup(12'h384, 12'h4B0);
    chk({audio_en_o, mute_o}, 2'h3);
    sup(12'h41A, 12'h4B0);
    chk(mute_o, 1'b1);
    sup(12'h47E, 12'h4B0);
    chk(mute_o, 1'b0);
    sup(12'h320, 12'h4B0);
    sup(12'h41A, 12'h4B0);
    chk(audio_en_o, 1'b0);
    sup(12'h47E, 12'h4B0);
    wait_for(0, 6'h1, 50);
    chk({n_rp, n_la}, {32'h1, 32'h0});
    sup(12'h1F4, 12'h4B0);
    sup(12'h47E, 12'h4B0);
    wait_for(0, 6'h1, 50);
    chk({n_rp, n_la}, {32'h1, 32'h1});
    apb(1, `REG_CTRL, {30'h0, `SCHEME_DEEP});
    sup(12'h320, 12'h4B0);
    chk({audio_en_o, mute_o}, 2'h3);
    sup(12'h1F4, 12'h4B0);
    chk(audio_en_o, 1'b0);
    sup(12'h47E, 12'h4B0);
    wait_for(0, 6'h1, 50);
    chk({n_la, n_rp}, {32'h2, 32'h1});
    apb(1, `REG_CTRL, {30'h0, `SCHEME_ADVANCED});
    sup(12'h384, 12'h4B0);
    sup(12'h41A, 12'h4B0);
    chk(atten_db_o, 6'h3);
    sup(12'h384, 12'h4B0);
    sup(12'h41A, 12'h4B0);
    chk(atten_db_o, 6'h3);
    tick(300);
    sup(12'h384, 12'h4B0);
    sup(12'h41A, 12'h4B0);
    chk(atten_db_o, 6'h6);
    tick(650);
    chk(atten_db_o, 6'h3);
    sup(12'h4B0, 12'h4B0);
    tick(650);
    chk(atten_db_o, 6'h0);
    sup(12'h4B0, 12'h384);
    wait_for(1, 6'h1, 110 * TK);
    tick(95);
    chk(atten_db_o, 6'h1);
    wait_for(1, 6'h2, 10 * TK);
    sup(12'h4B0, 12'h3E8);
    tick(120);
    chk(atten_db_o, 6'h2);
    sup(12'h4B0, 12'h384);
    wait_for(1, 6'h12, 1700 * TK);
    cyc(2);
    chk(mute_o, 1'b1);
    tick(200);
    chk(atten_db_o, 6'h12);
    apb(0, `REG_STATUS, 0);
    chk(q, 32'h7210);
    sup(12'h4B0, 12'h4B0);
    chk({mute_o, atten_db_o}, 7'h12);
    wait_for(1, 6'h11, 110 * TK);
    apb(1, `REG_LBTHR, 32'h3);
    apb(0, `REG_LBTHR, 0);
    chk(q, 32'h3);
    chk(thr, 4'h3);
    lowbat_below_i <= 1'b1;
    apb(1, `REG_CTRL, 32'h0);
    cyc(8);
    chk(n_lb, 0);
    apb(1, `REG_CTRL, 32'h4);
    cyc(8);
    chk(n_lb, 1);
    tick(3010);
    chk(n_lb, 2);
    conclude;
  end
endmodule // battery_power_manager_tb
